// ==== core/lsafc_regs.svh ====
// Register offsets, field positions and protocol constants of the live slot and fan host.
`ifndef LSAFC_REGS_SVH
`define LSAFC_REGS_SVH
`define LSAFC_OFF_CTRL     5'h00
`define LSAFC_OFF_STAT     5'h04
`define LSAFC_OFF_ARG0     5'h08
`define LSAFC_OFF_ARG1     5'h0C
`define LSAFC_OFF_RSP0     5'h10
`define LSAFC_OFF_RSP1     5'h14
`define LSAFC_OFF_RSP2     5'h18
`define LSAFC_CTRL_GO_BIT  0
`define LSAFC_CTRL_OP_LSB  1
`define LSAFC_STAT_BUSY    0
`define LSAFC_STAT_DONE    1
`define LSAFC_STAT_ERANGE  2
`define LSAFC_STAT_EREPLY  3
`define LSAFC_CMD_TYPE     8'h25
`define LSAFC_RSP_TYPE     8'h65
`define LSAFC_SUB_SLOT     8'h07
`define LSAFC_SUB_FAN      8'h08
`define LSAFC_SLOT_COUNT   8'h08
`define LSAFC_BOARD_COUNT  8'h20
`define LSAFC_FAN_COUNT    8'h04
`define LSAFC_ITEM_NONE    8'h00
`define LSAFC_ITEM_SPEED   8'h01
`define LSAFC_ITEM_TEMP    8'h02
`define LSAFC_ITEM_POWER   8'h03
`define LSAFC_TEMP_SENS    8'h10
`define LSAFC_FAN_SENS     8'h03
`define LSAFC_TSENS_MAX    8'h0F
`define LSAFC_COL3_MAX     8'h11
`define LSAFC_COL5_MAX     8'h0F
`define LSAFC_COL_SPAN     9'h014
`define LSAFC_ROW_MAX      8'h03
`define LSAFC_TGT_MIN      8'h58
`define LSAFC_PMIN_MAX     8'h63
`define LSAFC_PMAX_MAX     8'h64
`define LSAFC_LEN_CLR      8'h03
`define LSAFC_LEN_SLOT     8'h09
`define LSAFC_LEN_SRD      8'h02
`define LSAFC_LEN_FAN      8'h08
`define LSAFC_LEN_FRD      8'h03
`define LSAFC_LEN_ACK      8'h01
`endif

// ==== core/lsafc_pkg.sv ====
// Types shared by the live slot and fan host.
package lsafc_pkg;
  typedef enum logic [1:0] {OP_SLOT_SET, OP_SLOT_RD, OP_FAN_SET, OP_FAN_RD} lsafc_op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RECV, ST_CHECK} lsafc_state_type;
endpackage : lsafc_pkg

// ==== core/lsafc_host_ctrl.sv ====
// Host controller that builds slot and fan control packets and checks their replies.
//
// Overview of operation
// (R1) Device keeps eight independent live display slots.
// (R2) Slot set: type 0x25, sub 7, length 3/9.
// (R3) Item 0 clears with length 3, others 9.
// (R4) Slot, board and sensor indices within range.
// (R5) Digit count must suit the item type.
// (R6) Column and row must stay in range.
// (R7) Last byte: unit or divisor, power ignores.
// (R8) Slot set answered 0x65, length 1, echo.
// (R9) Slot read sends two bytes, gets nine.
// (R10) Boot state store keeps both settings.
// (R11) Host keeps all slot digits on display.
// (R12) Device ramps fan power toward target temperature.
// (R13) Below minimum: hold or off by policy.
// (R14) Device clamps fan power at maximum.
// (R15) Maximum power at startup or sensor loss.
// (R16) Control sensor sits on fan's board.
// (R17) Manual power ignored under automatic control.
// (R18) Fan set: type 0x25, sub 8, length 8.
// (R19) Option byte: enable, policy, reserved, responsiveness.
// (R20) Target is Celsius plus 128, 88 up.
// (R21) Sensor, minimum, maximum in range, maximum above.
// (R22) Fan read sends three bytes, gets eight.
// (R23) Device compares sixteenth-degree sensor readings.
// (R24) Bad requests are refused, settings unchanged.
//
// Added by the designer: register access over APB and the address map.
`include "lsafc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module lsafc_host_ctrl
  import lsafc_pkg::*;
#(
  // Sizes of the device's slot and fan tables.
  parameter int unsigned SLOT_COUNT  = 8,
  parameter int unsigned BOARD_COUNT = 32,
  parameter int unsigned FAN_COUNT   = 4
)
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Command byte stream toward the device.
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  // Reply byte stream from the device, on clk_sys.
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data
);

  lsafc_state_type state_ff;
  lsafc_state_type nxt_state;
  lsafc_op_type    op_ff;
  logic [31:0]     arg0_ff;
  logic [31:0]     arg1_ff;
  logic [7:0]      rsp_ff [0:8];
  logic [7:0]      rsp_type_ff;
  logic [7:0]      rsp_len_ff;
  logic [7:0]      idx_ff;
  logic [7:0]      nxt_idx;
  logic            done_ff;
  logic            erange_ff;
  logic            ereply_ff;
  logic            tx_valid_ff;
  logic [7:0]      tx_data_ff;
  logic [31:0]     prdata_ff;

  // Packet assembly: type, length, then the data bytes.
  logic [7:0] cmd_b [0:8];
  logic [7:0] pkt_b [0:10];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_args
      assign cmd_b[gi+1] = arg0_ff[8*gi +: 8];
      assign cmd_b[gi+5] = arg1_ff[8*gi +: 8];
    end
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_pkt
      assign pkt_b[gi+2] = cmd_b[gi];
    end
  endgenerate

  wire       is_slot   = (op_ff == OP_SLOT_SET) || (op_ff == OP_SLOT_RD);
  wire       is_clear  = (cmd_b[2] == `LSAFC_ITEM_NONE);
  wire [7:0] cmd_len   = (op_ff == OP_SLOT_SET) ? (is_clear ? `LSAFC_LEN_CLR : `LSAFC_LEN_SLOT) :
                         (op_ff == OP_SLOT_RD)  ? `LSAFC_LEN_SRD :
                         (op_ff == OP_FAN_SET)  ? `LSAFC_LEN_FAN : `LSAFC_LEN_FRD; // R2 R3 R9 R18 R22
  wire [7:0] exp_len   = (op_ff == OP_SLOT_RD) ? `LSAFC_LEN_SLOT :
                         (op_ff == OP_FAN_RD)  ? `LSAFC_LEN_FAN : `LSAFC_LEN_ACK; // R8 R9 R22
  assign cmd_b[0] = is_slot ? `LSAFC_SUB_SLOT : `LSAFC_SUB_FAN;
  assign pkt_b[0] = `LSAFC_CMD_TYPE;
  assign pkt_b[1] = cmd_len;

  // Slot field checks.
  wire is_temp    = (cmd_b[2] == `LSAFC_ITEM_TEMP);
  wire is_speed   = (cmd_b[2] == `LSAFC_ITEM_SPEED);
  wire is_power   = (cmd_b[2] == `LSAFC_ITEM_POWER);
  wire slot_ok    = (cmd_b[1] < 8'(SLOT_COUNT)); // R4
  wire sens_ok    = is_temp ? (cmd_b[4] <= `LSAFC_TEMP_SENS)
                            : (cmd_b[4] <= `LSAFC_FAN_SENS); // R4
  wire dig_ok     = is_temp  ? (cmd_b[5] == 8'h03 || cmd_b[5] == 8'h05) :
                    is_speed ? (cmd_b[5] == 8'h04 || cmd_b[5] == 8'h05) :
                    (cmd_b[5] == 8'h03); // R5
  wire col_ok     = !is_temp || (cmd_b[5] == 8'h03 ? cmd_b[6] <= `LSAFC_COL3_MAX
                                                   : cmd_b[6] <= `LSAFC_COL5_MAX); // R6
  wire [8:0] span = {1'b0, cmd_b[6]} + {1'b0, cmd_b[5]};
  wire fit_ok     = (span <= `LSAFC_COL_SPAN) && (cmd_b[7] <= `LSAFC_ROW_MAX); // R6 R11
  wire item_ok    = is_temp || is_speed || is_power;
  wire sset_ok    = slot_ok && (is_clear || (item_ok && cmd_b[3] < 8'(BOARD_COUNT)
                    && sens_ok && dig_ok && col_ok && fit_ok)); // R3 R4

  // Fan control field checks.
  wire fsel_ok    = (cmd_b[1] < 8'(BOARD_COUNT)) && (cmd_b[2] < 8'(FAN_COUNT)); // R16 R18
  // Reserved option bits 3:2 are refused here rather than left for the device to reject.
  wire opt_ok     = !cmd_b[3][2] && !cmd_b[3][3]; // R13 R19
  wire fset_ok    = fsel_ok && opt_ok && (cmd_b[4] <= `LSAFC_TSENS_MAX)
                    && (cmd_b[5] >= `LSAFC_TGT_MIN) && (cmd_b[6] <= `LSAFC_PMIN_MAX)
                    && (cmd_b[7] != 8'h00) && (cmd_b[7] <= `LSAFC_PMAX_MAX)
                    && (cmd_b[7] > cmd_b[6]); // R20 R21
  // The op arrives with the start bit, so the checks must use it and not the stored one.
  wire [1:0] req_op = pwdata[`LSAFC_CTRL_OP_LSB +: 2];
  wire args_ok    = (req_op == OP_SLOT_SET) ? sset_ok :
                    (req_op == OP_SLOT_RD)  ? slot_ok :
                    (req_op == OP_FAN_SET)  ? fset_ok : fsel_ok; // R24

  // APB decode; the slave answers with no wait state.
  wire acc      = psel && penable;
  wire hit      = (paddr <= `LSAFC_OFF_RSP2) && (paddr[1:0] == 2'b00);
  wire wr_ctrl  = acc && pwrite && (paddr == `LSAFC_OFF_CTRL);
  wire wr_stat  = acc && pwrite && (paddr == `LSAFC_OFF_STAT);
  wire wr_arg0  = acc && pwrite && (paddr == `LSAFC_OFF_ARG0) && (state_ff == ST_IDLE);
  wire wr_arg1  = acc && pwrite && (paddr == `LSAFC_OFF_ARG1) && (state_ff == ST_IDLE);
  wire go       = wr_ctrl && pwdata[`LSAFC_CTRL_GO_BIT] && (state_ff == ST_IDLE);
  wire go_op_ok = go && args_ok;
  wire [31:0] stat_word = {8'h00, rsp_len_ff, rsp_type_ff, 4'h0, ereply_ff, erange_ff,
                           done_ff, (state_ff != ST_IDLE)};
  wire [31:0] rd_word =
    (paddr == `LSAFC_OFF_CTRL) ? {29'h0000_0000, op_ff, 1'b0} :
    (paddr == `LSAFC_OFF_STAT) ? stat_word :
    (paddr == `LSAFC_OFF_ARG0) ? arg0_ff :
    (paddr == `LSAFC_OFF_ARG1) ? arg1_ff :
    (paddr == `LSAFC_OFF_RSP0) ? {rsp_ff[3], rsp_ff[2], rsp_ff[1], rsp_ff[0]} :
    (paddr == `LSAFC_OFF_RSP1) ? {rsp_ff[7], rsp_ff[6], rsp_ff[5], rsp_ff[4]} :
    (paddr == `LSAFC_OFF_RSP2) ? {24'h00_0000, rsp_ff[8]} : 32'h0000_0000;
  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // There is no reply timeout: a silent device keeps busy set until srst.
  // Sequencing of send, receive and reply check.
  wire tx_fire   = tx_valid_ff && tx_ready;
  wire tx_last   = (idx_ff == cmd_len + 8'h01);
  wire rx_last   = rx_valid && (idx_ff >= 8'h01) &&
                   (idx_ff == (idx_ff == 8'h01 ? 8'h01 : rsp_len_ff + 8'h01)) &&
                   !(idx_ff == 8'h01 && rx_data != 8'h00);
  wire reply_ok  = (rsp_type_ff == `LSAFC_RSP_TYPE) && (rsp_len_ff == exp_len)
                   && (rsp_ff[0] == cmd_b[0]); // R8 R9 R22
  wire [7:0] nxt_byte = pkt_b[4'(idx_ff + 8'h01)];

  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_idx = 8'h00;
        if (go_op_ok) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_fire) begin
          nxt_idx = tx_last ? 8'h00 : idx_ff + 8'h01;
          if (tx_last) begin
            nxt_state = ST_RECV;
          end
        end
      end
      ST_RECV: begin
        if (rx_valid) begin
          nxt_idx = idx_ff + 8'h01;
          if (rx_last) begin
            nxt_state = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      idx_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
    end
  end

  // Bytes are loaded one ahead so tx_data stands still while the device stalls.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (state_ff == ST_IDLE && go_op_ok) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff  <= `LSAFC_CMD_TYPE; // R2 R18
    end else if (tx_fire) begin
      tx_valid_ff <= !tx_last;
      tx_data_ff  <= tx_last ? 8'h00 : nxt_byte;
    end
  end
  assign tx_valid = tx_valid_ff;
  assign tx_data  = tx_data_ff;

  // Reply capture; bytes past the ninth are counted but dropped.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_type_ff <= 8'h00;
      rsp_len_ff  <= 8'h00;
      for (int i = 0; i < 9; i++) begin
        rsp_ff[i] <= 8'h00;
      end
    end else if (state_ff == ST_RECV && rx_valid) begin
      if (idx_ff == 8'h00) begin
        rsp_type_ff <= rx_data;
      end else if (idx_ff == 8'h01) begin
        rsp_len_ff <= rx_data;
      end else if (idx_ff <= 8'h0A) begin
        rsp_ff[4'(idx_ff - 8'h02)] <= rx_data;
      end
    end
  end

  // Register file; a hardware set wins over a software clear.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_ff     <= OP_SLOT_SET;
      arg0_ff   <= 32'h0000_0000;
      arg1_ff   <= 32'h0000_0000;
      done_ff   <= 1'b0;
      erange_ff <= 1'b0;
      ereply_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (psel && !penable) begin
        prdata_ff <= rd_word;
      end
      if (wr_ctrl && state_ff == ST_IDLE) begin
        op_ff <= lsafc_op_type'(pwdata[`LSAFC_CTRL_OP_LSB +: 2]);
      end
      if (wr_arg0) begin
        arg0_ff <= pwdata;
      end
      if (wr_arg1) begin
        arg1_ff <= pwdata;
      end
      done_ff   <= (state_ff == ST_CHECK) || (done_ff && !(wr_stat && pwdata[`LSAFC_STAT_DONE]));
      erange_ff <= (go && !args_ok) ||
                   (erange_ff && !(wr_stat && pwdata[`LSAFC_STAT_ERANGE])); // R24
      ereply_ff <= (state_ff == ST_CHECK && !reply_ok) ||
                   (ereply_ff && !(wr_stat && pwdata[`LSAFC_STAT_EREPLY])); // R8
    end
  end

  // Checks on the generated traffic.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_refused;
    go && !args_ok;
  endsequence
  sequence s_flagged;
    (state_ff == ST_IDLE && !tx_valid) ##1 erange_ff;
  endsequence

  a_refuse_bad_args: assert property (s_refused |=> s_flagged) // R24
    else $error("Out of range request was sent.");
  a_type_first: assert property ($rose(tx_valid) |-> tx_data == 8'h25) // R2
    else $error("Packet did not open with command type.");
  a_slot_length: assert property (tx_valid && idx_ff == 8'h01 && op_ff == OP_SLOT_SET // R3
      |-> tx_data == (is_clear ? 8'h03 : 8'h09))
    else $error("Slot set length wrong.");
  a_fan_length: assert property (tx_valid && idx_ff == 8'h01 && op_ff == OP_FAN_SET // R18
      |-> tx_data == 8'h08)
    else $error("Fan set length wrong.");
  a_sub_echo: assert property (tx_valid && idx_ff == 8'h02 // R2
      |-> tx_data == (is_slot ? 8'h07 : 8'h08))
    else $error("Subcommand byte wrong.");
  a_target_floor: assert property (tx_valid && idx_ff == 8'h07 && op_ff == OP_FAN_SET // R20
      |-> tx_data >= 8'h58)
    else $error("Target below floor sent.");
  a_max_above_min: assert property (tx_valid && idx_ff == 8'h09 && op_ff == OP_FAN_SET // R21
      |-> tx_data > arg1_ff[15:8] && tx_data <= 8'h64)
    else $error("Maximum power not above minimum.");
  a_read_length: assert property (tx_valid && idx_ff == 8'h01 && op_ff == OP_SLOT_RD // R9
      |-> tx_data == 8'h02)
    else $error("Slot read length wrong.");
  a_fan_rd_length: assert property (tx_valid && idx_ff == 8'h01 && op_ff == OP_FAN_RD // R22
      |-> tx_data == 8'h03)
    else $error("Fan read length wrong.");
  a_slot_range: assert property (tx_valid && idx_ff == 8'h03 && is_slot // R4
      |-> tx_data < 8'h08)
    else $error("Slot index out of range sent.");
  a_board_range: assert property (tx_valid && idx_ff == 8'h03 && !is_slot // R18
      |-> tx_data < 8'h20)
    else $error("Board index out of range sent.");
  a_option_reserved: assert property (tx_valid && idx_ff == 8'h05 && op_ff == OP_FAN_SET // R19
      |-> tx_data[3:2] == 2'b00)
    else $error("Reserved option bits sent.");
  a_sensor_range: assert property (tx_valid && idx_ff == 8'h06 && op_ff == OP_FAN_SET // R21
      |-> tx_data <= 8'h0F)
    else $error("Sensor index out of range sent.");
  a_reply_length: assert property (state_ff == ST_CHECK && rsp_len_ff != exp_len // R9
      |=> ereply_ff)
    else $error("Bad reply length not flagged.");
  a_echo_check: assert property (state_ff == ST_CHECK && rsp_ff[0] != cmd_b[0] // R8
      |=> ereply_ff)
    else $error("Bad reply echo not flagged.");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) // R2
    else $error("Byte changed while stalled.");
  a_reply_check: assert property (state_ff == ST_CHECK && rsp_type_ff != 8'h65
      |=> ereply_ff && done_ff) // R8
    else $error("Bad reply type not flagged.");

endmodule : lsafc_host_ctrl
`default_nettype wire

// ==== tb/lsafc_dev_model.sv ====
// Behavioural model of the display device that answers slot and fan packets.
`timescale 1ns/10ps
`default_nettype none
module lsafc_dev_model (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Scenario controls.
  input  wire logic       slow,
  input  wire logic       bad_reply,
  // Packet link.
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  logic [7:0] pk [0:10];
  logic [7:0] slot_tab [0:7][0:7];
  logic [7:0] fan_tab [0:127][0:7];
  logic [7:0] rp [$];
  logic       tgl = 1'b0;
  int         n = 0;
  // Slow mode stalls every other cycle in both directions.
  assign tx_ready = !slow || tgl;
  task automatic answer();
    logic [6:0] f;
    f = {pk[3][4:0], pk[4][1:0]};
    rp.push_back(bad_reply ? 8'h45 : 8'h65);
    if (pk[2] == 8'h07 && pk[1] == 8'h02) begin
      rp.push_back(8'h09);
      rp.push_back(8'h07);
      for (int k = 0; k < 8; k++) rp.push_back(slot_tab[pk[3][2:0]][k]);
    end else if (pk[2] == 8'h08 && pk[1] == 8'h03) begin
      rp.push_back(8'h08);
      rp.push_back(8'h08);
      for (int k = 0; k < 7; k++) rp.push_back(fan_tab[f][k]);
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (pk[2] == 8'h07) slot_tab[pk[3][2:0]][k] = (k < pk[1] - 1) ? pk[k+3] : 8'h00;
        else fan_tab[f][k] = pk[k+3];
      end
      rp.push_back(8'h01);
      rp.push_back(pk[2]);
    end
  endtask
  // The reply queue is served before the parse so a reply never starts on the last byte.
  always @(posedge clk_sys) begin
    tgl <= ~tgl;
    if (srst) begin
      n = 0;
      rp = {};
      rx_valid <= 1'b0;
      rx_data <= 8'h5A;
    end else begin
      if (rp.size() > 0 && !(slow && tgl)) begin
        rx_valid <= 1'b1;
        rx_data <= rp.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
      if (tx_valid && tx_ready) begin
        pk[n] = tx_data;
        n++;
        if (n > 1 && n == int'(pk[1]) + 2) begin
          answer();
          n = 0;
        end
      end
    end
  end
endmodule : lsafc_dev_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the live slot and fan host controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct {
    logic [1:0]  op;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [31:0] mask;
    logic [31:0] stat;
    logic [31:0] rsp;
  } lsafc_row_type;
  logic          clk_sys = 1'b0;
  logic          srst = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [4:0]    paddr = 5'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          tx_valid;
  logic [7:0]    tx_data;
  logic          tx_ready;
  logic          rx_valid;
  logic [7:0]    rx_data;
  logic          slow = 1'b0;
  logic          bad_reply = 1'b0;
  logic          err_seen;
  logic [31:0]   q;
  int            failures = 0;
  int            n_compared = 0;
  lsafc_row_type rows [18];
  lsafc_host_ctrl dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));
  lsafc_dev_model model (.clk_sys(clk_sys), .srst(srst), .slow(slow), .bad_reply(bad_reply),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      apb(1'b0, 5'h04, 32'h0);
      t++;
    end while (q[0] !== 1'b0 && t < 200);
    if (q[0] !== 1'b0) failures++;
  endtask : wait_idle
  task automatic run(input logic [1:0] op, input logic [31:0] a0, input logic [31:0] a1);
    apb(1'b1, 5'h04, 32'h0000000E);
    apb(1'b1, 5'h08, a0);
    apb(1'b1, 5'h0C, a1);
    apb(1'b1, 5'h00, {29'h0, op, 1'b1});
    wait_idle();
  endtask : run
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial begin
    rows = '{
      '{2'h0, 32'h101F0207, 32'h01030F05, 32'h00FFFF0F, 32'h00016502, 32'h0},
      '{2'h1, 32'h00000007, 32'h0, 32'h00FFFF0F, 32'h00096502, 32'h1F020707},
      '{2'h0, 32'h03000301, 32'hFF031103, 32'h00FFFF0F, 32'h00016502, 32'h0},
      '{2'h0, 32'h03010102, 32'h02000005, 32'h00FFFF0F, 32'h00016502, 32'h0},
      '{2'h0, 32'h00000000, 32'h0, 32'h00FFFF0F, 32'h00016502, 32'h0},
      '{2'h2, 32'h0FF3031F, 32'h00646358, 32'h00FFFF0F, 32'h00016502, 32'h0},
      '{2'h3, 32'h0000031F, 32'h0, 32'h00FFFF0F, 32'h00086502, 32'hF3031F08},
      '{2'h0, 32'h101F0208, 32'h01030F05, 32'h5, 32'h4, 32'h0},
      '{2'h0, 32'h101F0207, 32'h00031203, 32'h5, 32'h4, 32'h0},
      '{2'h0, 32'h03000301, 32'h00000004, 32'h5, 32'h4, 32'h0},
      '{2'h0, 32'h101F0407, 32'h01030F05, 32'h5, 32'h4, 32'h0},
      '{2'h0, 32'h10200207, 32'h01030F05, 32'h5, 32'h4, 32'h0},
      '{2'h2, 32'h0FF3031F, 32'h00646357, 32'h5, 32'h4, 32'h0},
      '{2'h2, 32'h0FF3031F, 32'h00323258, 32'h5, 32'h4, 32'h0},
      '{2'h2, 32'h0F09031F, 32'h00646358, 32'h5, 32'h4, 32'h0},
      '{2'h2, 32'h0F05031F, 32'h00646358, 32'h5, 32'h4, 32'h0},
      '{2'h2, 32'h10F3031F, 32'h00646358, 32'h5, 32'h4, 32'h0},
      '{2'h1, 32'h00000007, 32'h0, 32'h00FFFF0F, 32'h00096502, 32'h1F020707}};
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 5'h04, 32'h0);
    check(q, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a0, rows[i].a1);
      check(q & rows[i].mask, rows[i].stat);
      if (rows[i].op[0]) begin
        apb(1'b0, 5'h10, 32'h0);
        check(q, rows[i].rsp);
      end
      $display("row %0d done", i);
    end
    apb(1'b0, 5'h1C, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    run(2'h3, 32'h0000031F, 32'h0);
    apb(1'b0, 5'h14, 32'h0);
    check(q, 32'h6463580F);
    $display("unmapped and fan readback test done");
    slow <= 1'b1;
    bad_reply <= 1'b1;
    run(2'h1, 32'h00000007, 32'h0);
    check(q & 32'h0000000F, 32'h0000000A);
    bad_reply <= 1'b0;
    $display("bad reply test done");
    // A second order while busy must be dropped, so the reply stays a slot read.
    apb(1'b1, 5'h04, 32'h0000000E);
    apb(1'b1, 5'h00, 32'h00000003);
    apb(1'b1, 5'h08, 32'h00000001);
    apb(1'b1, 5'h00, 32'h00000005);
    wait_idle();
    check(q & 32'h00FFFF0F, 32'h00096502);
    apb(1'b0, 5'h10, 32'h0);
    check(q, 32'h1F020707);
    $display("busy and stall test done");
    apb(1'b1, 5'h00, 32'h00000003);
    repeat (4) @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 5'h04, 32'h0);
    check(q, 32'h0);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
